/* fecc_ctrl.sv */
// nvm command front end: reset init, divider, command object, launch gating
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "fecc_defines.svh"
module fecc_ctrl
   import fecc_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int HOLD_CYCLES = `FECC_HOLD_CYCLES
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite write
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // nonvolatile configuration reads during init
   output logic nv_req,
   output logic [1:0] nv_index,
   input wire fecc_nv_rsp_s nv_rsp,
   // command execution engine
   output logic cmd_start,
   output logic cmd_active,
   output fecc_cmd_s cmd,
   input wire fecc_ctl_rsp_s ctl_rsp,
   // system
   input wire logic stop_request,
   output logic stop_ack,
   output logic cpu_hold,
   output logic array_read_en
);
   localparam int CNT_W = $clog2(HOLD_CYCLES + 1);

   fecc_init_e state;
   fecc_init_e next_state;
   logic [CNT_W-1:0] hold_cnt;
   logic init_err;
   logic init_dbl;
   logic [7:0] flash_protection_reg;
   logic [7:0] eeprom_protection_reg;
   logic [7:0] opt;
   logic [7:0] sec;
   logic [5:0] divider_value;
   logic divider_loaded;
   logic ccf;
   logic access_error_flag;
   logic protection_violation_flag;
   logic [1:0] verify_status_bits;
   logic [2:0] command_word_index;
   logic [15:0] cobj [0:7];

   // bus handshake state
   logic aw_got;
   logic w_got;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   wire aw_hs = ce & awvalid & awready;
   wire w_hs = ce & wvalid & wready;
   wire ar_hs = ce & arvalid & arready;
   wire wr_go = ce & aw_got & w_got & ~bvalid;
   wire next_aw_got = (aw_got & ~wr_go) | aw_hs;
   wire next_w_got = (w_got & ~wr_go) | w_hs;
   wire next_bvalid = (bvalid & ~bready) | wr_go;
   wire next_rvalid = (rvalid & ~rready) | ar_hs;
   wire run = (state == st_run);

   // write decode
   wire [7:0] wa = aw_addr_q[7:0];
   wire wr_mapped = (wa[1:0] == 2'b00) && (wa <= `FECC_OFF_SEC);
   wire wr_clkdiv = wr_go & (wa == `FECC_OFF_CLKDIV) & w_strb_q[0];
   wire wr_stat = wr_go & (wa == `FECC_OFF_STATUS) & w_strb_q[0];
   wire wr_index = wr_go & (wa == `FECC_OFF_INDEX) & w_strb_q[0];
   wire wr_cobj = wr_go & (wa == `FECC_OFF_COBJ) & (|w_strb_q[1:0]);
   wire clr_acc = wr_stat & w_data_q[`FECC_STAT_ACCESS_ERROR_FLAG];
   wire clr_pv = wr_stat & w_data_q[`FECC_STAT_PROTECTION_VIOLATION_FLAG];
   // a zero in the flag bit and a busy flag both leave it alone
   wire launch_req = wr_stat & w_data_q[`FECC_STAT_CCF] & ccf & run;

   // command checks on the staged object
   wire [7:0] code = cobj[0][15:8];
   wire [23:0] caddr = {cobj[0][7:0], cobj[1]};
   wire is_pe = (code == cmd_program_flash) || (code == cmd_program_once)
      || (code == cmd_erase_all) || (code == cmd_erase_flash_block)
      || (code == cmd_erase_sector) || (code == cmd_ee_program)
      || (code == cmd_ee_erase_sector);
   wire known = is_pe || (code == cmd_erase_verify_all)
      || (code == cmd_erase_verify_block) || (code == cmd_read_once)
      || (code == cmd_erase_verify_section) || (code == cmd_unsecure)
      || (code == cmd_verify_backdoor) || (code == cmd_set_margin)
      || (code == cmd_ee_erase_verify);
   wire unsecured = (sec[1:0] == `FECC_SEC_UNSECURED);
   wire sec_ok = unsecured ? (code != cmd_unsecure) :
      ((code == cmd_erase_verify_all) || (code == cmd_erase_verify_block)
      || (code == cmd_erase_all) || (code == cmd_erase_flash_block)
      || (code == cmd_unsecure) || (code == cmd_verify_backdoor));
   wire flash_addr = (code != cmd_program_flash) && (code != cmd_erase_sector)
      || ((caddr[23:16] == 8'h00) && (caddr[15:0] >= `FECC_FLASH_BASE));
   wire launch_bad = (is_pe & ~divider_loaded)
      | ~known | ~sec_ok | ~flash_addr;
   wire launch_ok = launch_req & ~launch_bad;
   wire launch_fail = launch_req & launch_bad;
   wire cmd_done = ce & ctl_rsp.done & cmd_active;

   // init sequencing
   wire nv_take = ce & nv_req & nv_rsp.valid;
   wire init_finish = (state == st_load) & nv_take & (nv_index == 2'd3);
   wire init_bad = init_err | nv_rsp.err | nv_rsp.dbl;
   wire next_ccf = (ccf & ~launch_ok) | cmd_done | init_finish;

   always_comb begin
      next_state = state;
      unique case (state)
         st_hold: if (ce && hold_cnt == CNT_W'(HOLD_CYCLES - 1)) begin
            next_state = st_load;
         end
         st_load: if (init_finish) begin
            next_state = st_run;
         end
         st_run: next_state = st_run;
         default: next_state = st_hold;
      endcase
   end

   // a reset restarts init and drops any command in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= st_hold;
         hold_cnt <= '0;
         nv_req <= 1'b0;
         nv_index <= 2'd0;
         init_err <= 1'b0;
         init_dbl <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         if (state == st_hold) begin
            hold_cnt <= hold_cnt + CNT_W'(1);
         end
         if (state == st_hold && next_state == st_load) begin
            nv_req <= 1'b1;
         end
         if (nv_take) begin
            init_err <= init_bad;
            init_dbl <= init_dbl | nv_rsp.dbl;
            nv_index <= nv_index + 2'd1;
            nv_req <= ~init_finish;
         end
      end
   end

   // configuration bytes, replaced by safe defaults if any load went bad
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flash_protection_reg <= `FECC_DEF_FLASH_PROTECTION_REG;
         eeprom_protection_reg <= `FECC_DEF_EEPROM_PROTECTION_REG;
         opt <= `FECC_DEF_OPT;
         sec <= `FECC_DEF_SEC;
      end else if (init_finish && init_bad) begin
         flash_protection_reg <= `FECC_DEF_FLASH_PROTECTION_REG;
         eeprom_protection_reg <= `FECC_DEF_EEPROM_PROTECTION_REG;
         opt <= `FECC_DEF_OPT;
         sec <= `FECC_DEF_SEC;
      end else if (nv_take) begin
         unique case (nv_index)
            2'd0: flash_protection_reg <= nv_rsp.data;
            2'd1: eeprom_protection_reg <= nv_rsp.data;
            2'd2: opt <= nv_rsp.data;
            2'd3: sec <= nv_rsp.data;
         endcase
      end
   end

   // status and divider
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ccf <= 1'b0;
         access_error_flag <= 1'b0;
         protection_violation_flag <= 1'b0;
         verify_status_bits <= 2'b00;
         divider_value <= 6'h00;
         divider_loaded <= 1'b0;
         command_word_index <= 3'd0;
      end else if (ce) begin
         ccf <= next_ccf;
         // a hardware set wins over a software clear in the same cycle
         access_error_flag <= (access_error_flag & ~clr_acc) | launch_fail
            | (cmd_done & ctl_rsp.access_error_flag);
         protection_violation_flag <= (protection_violation_flag & ~clr_pv) | (cmd_done & ctl_rsp.protection_violation_flag);
         if (init_finish && (init_dbl || nv_rsp.dbl)) begin
            verify_status_bits <= 2'b11;
         end else if (cmd_done) begin
            verify_status_bits <= ctl_rsp.verify;
         end else if (launch_ok) begin
            verify_status_bits <= 2'b00;
         end
         if (wr_clkdiv) begin
            divider_value <= w_data_q[5:0];
            divider_loaded <= 1'b1;
         end
         if (wr_index) begin
            command_word_index <= w_data_q[2:0];
         end
      end
   end

   // command object words; software writes only while the flag is set
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_word
         logic [15:0] word;
         wire sel = (command_word_index == 3'(gi));
         wire sw_we = wr_cobj & ccf & run & sel;
         wire hw_we = ce & cmd_active & ctl_rsp.res_we
            & (ctl_rsp.res_idx == 3'(gi));
         if (gi < `FECC_COBJ_WORDS) begin : g_impl
            always_ff @(posedge aclk) begin
               if (!aresetn) begin
                  word <= 16'h0000;
               end else if (sw_we) begin
                  if (w_strb_q[0]) begin
                     word[7:0] <= w_data_q[7:0];
                  end
                  if (w_strb_q[1]) begin
                     word[15:8] <= w_data_q[15:8];
                  end
               end else if (hw_we) begin
                  word <= ctl_rsp.res_data;
               end
            end
         end else begin : g_none
            assign word = 16'h0000;
         end
         assign cobj[gi] = word;
      end
   endgenerate

   // handover to the execution engine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_start <= 1'b0;
         cmd_active <= 1'b0;
         cmd <= '0;
         stop_ack <= 1'b0;
         cpu_hold <= 1'b1;
         array_read_en <= 1'b0;
      end else if (ce) begin
         cmd_start <= launch_ok;
         cmd_active <= (cmd_active & ~cmd_done) | launch_ok;
         if (launch_ok) begin
            cmd <= '{command_code: code, addr: caddr,
               data: {cobj[2], cobj[3], cobj[4], cobj[5]}};
         end
         stop_ack <= stop_request & next_ccf & (next_state == st_run);
         cpu_hold <= (next_state == st_hold);
         array_read_en <= (next_state != st_hold);
      end
   end

   // read mux
   wire [7:0] ra = araddr[7:0];
   wire rd_mapped = (ra[1:0] == 2'b00) && (ra <= `FECC_OFF_SEC);
   wire [31:0] rd_word =
      (ra == `FECC_OFF_CLKDIV) ? {24'h0000_00, divider_loaded, 1'b0,
                                  divider_value} :
      (ra == `FECC_OFF_STATUS) ? {24'h0000_00, ccf, 1'b0, access_error_flag, protection_violation_flag,
                                  2'b00, verify_status_bits} :
      (ra == `FECC_OFF_INDEX) ? {29'h0000_0000, command_word_index} :
      (ra == `FECC_OFF_COBJ) ? {16'h0000, cobj[command_word_index]} :
      (ra == `FECC_OFF_FLASH_PROTECTION_REG) ? {24'h0000_00, flash_protection_reg} :
      (ra == `FECC_OFF_EEPROM_PROTECTION_REG) ? {24'h0000_00, eeprom_protection_reg} :
      (ra == `FECC_OFF_OPT) ? {24'h0000_00, opt} :
      (ra == `FECC_OFF_SEC) ? {24'h0000_00, sec} : 32'h0000_0000;

   // axi4-lite slave; address channels stay closed during the init hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `FECC_RESP_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `FECC_RESP_OKAY;
      end else if (ce) begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         if (aw_hs) begin
            aw_addr_q <= awaddr;
         end
         if (w_hs) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         awready <= ~next_aw_got & (next_state != st_hold);
         wready <= ~next_w_got & (next_state != st_hold);
         bvalid <= next_bvalid;
         if (wr_go) begin
            bresp <= wr_mapped ? `FECC_RESP_OKAY : `FECC_RESP_SLVERR;
         end
         arready <= ~next_rvalid & (next_state != st_hold);
         rvalid <= next_rvalid;
         if (ar_hs) begin
            rdata <= rd_mapped ? rd_word : 32'h0000_0000;
            rresp <= rd_mapped ? `FECC_RESP_OKAY : `FECC_RESP_SLVERR;
         end
      end
   end

   // checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // word under the index one edge ago, for the lock check
   logic [15:0] cobj_sel_prev;
   always_ff @(posedge aclk) begin
      cobj_sel_prev <= cobj[command_word_index];
   end

   property p_init_flag;
      !run |-> !ccf && !cmd_active;
   endproperty
   a_init_flag: assert property (p_init_flag)
      else $error("complete flag or command active during init");

   property p_init_end;
      init_finish |=> ccf && run;
   endproperty
   a_init_end: assert property (p_init_end)
      else $error("complete flag not set at end of init");

   property p_hold;
      cpu_hold |-> !awready && !wready && !arready;
   endproperty
   a_hold: assert property (p_hold)
      else $error("bus accepted during init hold");

   property p_defaults;
      init_finish && init_bad |=> sec == `FECC_DEF_SEC
         && flash_protection_reg == `FECC_DEF_FLASH_PROTECTION_REG && eeprom_protection_reg == `FECC_DEF_EEPROM_PROTECTION_REG;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("defaults not applied after init error");

   property p_dbl;
      init_finish && nv_rsp.dbl |=> verify_status_bits == 2'b11;
   endproperty
   a_dbl: assert property (p_dbl)
      else $error("double fault did not set verify status");

   property p_divld;
      wr_clkdiv |=> divider_loaded ##1 divider_loaded;
   endproperty
   a_divld: assert property (p_divld)
      else $error("divider loaded bit not set by write");

   property p_nodiv;
      launch_req && is_pe && !divider_loaded |=> access_error_flag && ccf && !cmd_start;
   endproperty
   a_nodiv: assert property (p_nodiv)
      else $error("command ran without divider");

   property p_lock;
      wr_cobj && !ccf && !(cmd_active && ctl_rsp.res_we)
         |=> cobj[command_word_index] == cobj_sel_prev;
   endproperty
   a_lock: assert property (p_lock)
      else $error("command object changed while locked");

   property p_launch;
      launch_ok |=> !ccf && cmd_start && cmd_active ##1 !cmd_start;
   endproperty
   a_launch: assert property (p_launch)
      else $error("launch did not start the command");

   property p_secure;
      launch_req && !unsecured && code == cmd_erase_sector |=> !cmd_start;
   endproperty
   a_secure: assert property (p_secure)
      else $error("forbidden command ran while secured");

   property p_stop;
      stop_ack |-> ccf && !cmd_active;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop granted during a command");

   property p_zero_write;
      wr_stat && !w_data_q[`FECC_STAT_CCF] && ccf && !cmd_done |=> ccf;
   endproperty
   a_zero_write: assert property (p_zero_write)
      else $error("writing zero changed the complete flag");

   c_launch: cover property (launch_ok ##[1:100] cmd_done);
   c_fail: cover property (launch_fail);
   c_init_err: cover property (init_finish && init_bad);
   c_stop: cover property (stop_request && !ccf ##[1:50] stop_ack);
endmodule

/* fecc_defines.svh */
// offsets, field positions, reset values and timing counts of the nvm front end
// Functional notes
// - flash is the top 4 KB at 0xF000, eight 512-byte sectors, all usable.
// - every reset runs init loading protection, option and security registers.
// - init errors load defaults: memories fully protected, device secured.
// - double-bit fault during init sets both verify status bits.
// - complete flag stays 0 during init, set at end; commands only then.
// - cpu accesses stall during part of init; array reads allowed afterwards.
// - reset aborts any running program or erase command at once.
// - any divider register write sets divider_loaded; reads 0 until written.
// - program/erase launch without loaded divider does not run; sets access error.
// - while complete flag is 0, command object writes are ignored.
// - 3-bit index selects word: code/addr high, addr low, data 0 to 3.
// - indices 6 and 7 ignore writes and read as 0x0000.
// - writing 1 to complete flag clears it, hands over object, starts command.
// - object locked while running; controller sets complete flag when done.
// - result data lands in command object, readable once flag is 1.
// - flash command codes 0x01 to 0x0C as listed.
// - codes 0x0D margin, 0x10 eeprom verify, 0x11 eeprom program, 0x12 erase.
// - secured state allows only 01,02,08,09,0B,0C; 0B only when secured.
// - stop request waits until an active command has finished.
`ifndef FECC_DEFINES_SVH
`define FECC_DEFINES_SVH

`define FECC_OFF_CLKDIV 8'h00
`define FECC_OFF_STATUS 8'h04
`define FECC_OFF_INDEX 8'h08
`define FECC_OFF_COBJ 8'h0C
`define FECC_OFF_FLASH_PROTECTION_REG 8'h10
`define FECC_OFF_EEPROM_PROTECTION_REG 8'h14
`define FECC_OFF_OPT 8'h18
`define FECC_OFF_SEC 8'h1C

`define FECC_CLKDIV_LD 7
`define FECC_STAT_CCF 7
`define FECC_STAT_ACCESS_ERROR_FLAG 5
`define FECC_STAT_PROTECTION_VIOLATION_FLAG 4

`define FECC_DEF_FLASH_PROTECTION_REG 8'h20
`define FECC_DEF_EEPROM_PROTECTION_REG 8'h03
`define FECC_DEF_OPT 8'hFF
`define FECC_DEF_SEC 8'hFF
`define FECC_SEC_UNSECURED 2'b10

`define FECC_FLASH_BASE 16'hF000
`define FECC_SECTOR_BYTES 16'h0200
`define FECC_NUM_SECTORS 8
`define FECC_COBJ_WORDS 6

`define FECC_CLK_PERIOD_NS 25
`define FECC_HOLD_NS 1000
`define FECC_HOLD_CYCLES \
   ((`FECC_HOLD_NS + `FECC_CLK_PERIOD_NS - 1) / `FECC_CLK_PERIOD_NS)

`define FECC_RESP_OKAY 2'b00
`define FECC_RESP_SLVERR 2'b10

`endif

/* fecc_pkg.sv */
// types shared by the nvm command front end
package fecc_pkg;
   typedef enum logic [1:0] {
      st_hold = 2'b00,
      st_load = 2'b01,
      st_run = 2'b10
   } fecc_init_e;

   typedef enum logic [7:0] {
      cmd_erase_verify_all = 8'h01,
      cmd_erase_verify_block = 8'h02,
      cmd_erase_verify_section = 8'h03,
      cmd_read_once = 8'h04,
      cmd_program_flash = 8'h06,
      cmd_program_once = 8'h07,
      cmd_erase_all = 8'h08,
      cmd_erase_flash_block = 8'h09,
      cmd_erase_sector = 8'h0A,
      cmd_unsecure = 8'h0B,
      cmd_verify_backdoor = 8'h0C,
      cmd_set_margin = 8'h0D,
      cmd_ee_erase_verify = 8'h10,
      cmd_ee_program = 8'h11,
      cmd_ee_erase_sector = 8'h12
   } fecc_cmd_e;

   typedef struct packed {
      logic [7:0] command_code;
      logic [23:0] addr;
      logic [63:0] data;
   } fecc_cmd_s;

   typedef struct packed {
      logic valid;
      logic err;
      logic dbl;
      logic [7:0] data;
   } fecc_nv_rsp_s;

   typedef struct packed {
      logic done;
      logic access_error_flag;
      logic protection_violation_flag;
      logic [1:0] verify;
      logic res_we;
      logic [2:0] res_idx;
      logic [15:0] res_data;
   } fecc_ctl_rsp_s;
endpackage

/* flash_eeprom_command_ctrl_tb.sv */
// self-checking bench for the nvm command front end
`timescale 1ns/1ps
`include "fecc_defines.svh"
module flash_eeprom_command_ctrl_tb;
   import fecc_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} fecc_row_s;
   logic aclk = 0, aresetn = 0, ce = 1;
   logic [7:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdata, rv;
   logic [3:0] wstrb = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rr, nv_index;
   logic nv_req, cmd_start, cmd_active, stop_ack, cpu_hold, array_read_en;
   fecc_nv_rsp_s nv_rsp = '0;
   fecc_ctl_rsp_s ctl_rsp = '0;
   fecc_cmd_s cmd;
   logic stop_request = 0, nv_go = 0, nv_err = 0, nv_dbl = 0;
   logic [7:0] nv_bytes [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hFE};
   int failures = 0, cmp_count = 0, n_start = 0;
   // rows 0..6 after a clean init, rows 7..13 after a faulty one
   fecc_row_s rows [14] = '{
      '{8'h00, 32'h0, 2'h0}, '{8'h04, 32'h80, 2'h0}, '{8'h10, 32'hA5, 2'h0},
      '{8'h14, 32'h5A, 2'h0}, '{8'h18, 32'h3C, 2'h0}, '{8'h1C, 32'hFE, 2'h0},
      '{8'h20, 32'h0, 2'h2}, '{8'h00, 32'h0, 2'h0}, '{8'h04, 32'h83, 2'h0},
      '{8'h10, 32'h20, 2'h0}, '{8'h14, 32'h03, 2'h0}, '{8'h18, 32'hFF, 2'h0},
      '{8'h1C, 32'hFF, 2'h0}, '{8'h24, 32'h0, 2'h2}};

   always #12.5 aclk = ~aclk;

   fecc_ctrl #(.ADDR_W(8), .HOLD_CYCLES(2)) dut_u (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .nv_req(nv_req), .nv_index(nv_index), .nv_rsp(nv_rsp),
      .cmd_start(cmd_start), .cmd_active(cmd_active), .cmd(cmd),
      .ctl_rsp(ctl_rsp), .stop_request(stop_request), .stop_ack(stop_ack),
      .cpu_hold(cpu_hold), .array_read_en(array_read_en));

   // nonvolatile store answers every other cycle so each byte is a fresh pulse
   always @(posedge aclk) begin
      if (nv_go && nv_req === 1'b1 && !nv_rsp.valid)
         nv_rsp <= '{1'b1, nv_err, nv_dbl, nv_bytes[nv_index]};
      else
         nv_rsp.valid <= 1'b0;
      if (cmd_start === 1'b1)
         n_start <= n_start + 1;
   end

   task automatic chk(input string nm, input logic [95:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ad, wd;
      n = 0;
      ad = 0;
      wd = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (!ad && awready === 1'b1) begin
            ad = 1;
            awvalid <= 0;
         end
         if (!wd && wready === 1'b1) begin
            wd = 1;
            wvalid <= 0;
         end
      end while (bvalid !== 1'b1 && n < 100);
      bready <= 0;
      rr = bresp;
      if (n >= 100) failures++;
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      logic ad;
      n = 0;
      ad = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (!ad && arready === 1'b1) begin
            ad = 1;
            arvalid <= 0;
         end
      end while (rvalid !== 1'b1 && n < 100);
      rready <= 0;
      rv = rdata;
      rr = rresp;
      if (n >= 100) failures++;
   endtask

   task automatic rc(input string nm, input logic [7:0] a, logic [31:0] e);
      rd(a);
      chk(nm, rv, e);
   endtask

   task automatic launch(input logic [15:0] w0);
      wr(`FECC_OFF_INDEX, 32'h0000_0000);
      wr(`FECC_OFF_COBJ, {16'h0000, w0});
      wr(`FECC_OFF_STATUS, 32'h0000_0080);
      repeat (2) @(posedge aclk);
   endtask

   task automatic check_rows(input int base);
      for (int i = base; i < base + 7; i++) begin
         rd(rows[i].a);
         chk("register", rv, rows[i].d);
         chk("response", rr, rows[i].r);
      end
   endtask

   task automatic do_reset(input logic e, input logic d);
      int n;
      @(posedge aclk);
      aresetn <= 0;
      nv_go <= 0;
      nv_err <= e;
      nv_dbl <= d;
      repeat (10) @(posedge aclk);
      chk("reset outputs", {cpu_hold, array_read_en, cmd_active}, 3'b100);
      aresetn <= 1;
      repeat (6) @(posedge aclk);
      rc("flag during init", `FECC_OFF_STATUS, 32'h0000_0000);
      nv_go <= 1;
      n = 0;
      do begin
         rd(`FECC_OFF_STATUS);
         n++;
      end while (rv[7] !== 1'b1 && n < 20);
      chk("hold released", {cpu_hold, array_read_en}, 2'b01);
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #200000;
      failures++;
      complete_run;
   end

   initial begin
      do_reset(0, 0);
      check_rows(0);
      // program without a loaded divider must be refused
      wr(`FECC_OFF_INDEX, 32'h0000_0001);
      wr(`FECC_OFF_COBJ, 32'h0000_F004);
      launch(16'h0600);
      chk("start count", n_start, 0);
      rc("access error", `FECC_OFF_STATUS, 32'h0000_00A0);
      wr(`FECC_OFF_STATUS, 32'h0000_0020);
      rc("error cleared", `FECC_OFF_STATUS, 32'h0000_0080);
      // 40 MHz bus is well above the lowest clock for program or erase
      wr(`FECC_OFF_CLKDIV, 32'h0000_0013);
      chk("write response", rr, `FECC_RESP_OKAY);
      rc("divider", `FECC_OFF_CLKDIV, 32'h0000_0093);
      for (int i = 2; i < 8; i++) begin
         wr(`FECC_OFF_INDEX, i);
         wr(`FECC_OFF_COBJ, i < 6 ? 32'h0000_A000 + i : 32'h0000_BEEF);
      end
      for (int i = 1; i < 8; i++) begin
         wr(`FECC_OFF_INDEX, i);
         rd(`FECC_OFF_COBJ);
         chk("object word", rv, i == 1 ? 32'h0000_F004 :
             i < 6 ? 32'h0000_A000 + i : 32'h0000_0000);
      end
      wr(`FECC_OFF_INDEX, 32'h0000_0000);
      wr(`FECC_OFF_COBJ, 32'h0000_0600);
      wr(`FECC_OFF_INDEX, 32'h0000_0002);
      wr(`FECC_OFF_STATUS, 32'h0000_0000);
      repeat (2) @(posedge aclk);
      chk("zero write", n_start, 0);
      wr(`FECC_OFF_STATUS, 32'h0000_0080);
      repeat (2) @(posedge aclk);
      chk("launch", n_start, 1);
      chk("command", cmd, {8'h06, 24'h00_F004, 64'hA002_A003_A004_A005});
      rc("flag cleared", `FECC_OFF_STATUS, 32'h0000_0000);
      wr(`FECC_OFF_COBJ, 32'h0000_5555);
      stop_request <= 1;
      repeat (4) @(posedge aclk);
      chk("stop held off", stop_ack, 0);
      ctl_rsp <= '{1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 3'h3, 16'h7777};
      @(posedge aclk);
      ctl_rsp <= '{1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 3'h0, 16'h0000};
      @(posedge aclk);
      ctl_rsp <= '0;
      repeat (3) @(posedge aclk);
      chk("stop granted", {stop_ack, cmd_active}, 2'b10);
      stop_request <= 0;
      rc("flag set", `FECC_OFF_STATUS, 32'h0000_0080);
      rc("locked word", `FECC_OFF_COBJ, 32'h0000_A002);
      wr(`FECC_OFF_INDEX, 32'h0000_0003);
      rc("result", `FECC_OFF_COBJ, 32'h0000_7777);
      launch(16'h0B00);
      chk("unsecure refused", n_start, 1);
      rc("unsecure error", `FECC_OFF_STATUS, 32'h0000_00A0);
      wr(`FECC_OFF_STATUS, 32'h0000_0020);
      launch(16'h0100);
      chk("verify running", {n_start[1:0], cmd_active}, 3'b101);
      // reset in mid-command with faulty configuration bytes
      do_reset(1, 1);
      check_rows(7);
      launch(16'h0A00);
      chk("secured refusal", n_start, 2);
      rc("secured error", `FECC_OFF_STATUS, 32'h0000_00A3);
      wr(`FECC_OFF_STATUS, 32'h0000_0020);
      launch(16'h0B00);
      chk("secured unsecure", n_start, 3);
      // a done pulse while the enable is low must not end the command
      ce <= 0;
      ctl_rsp <= '{1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 3'h0, 16'h0000};
      @(posedge aclk);
      ctl_rsp <= '0;
      @(posedge aclk);
      ce <= 1;
      repeat (2) @(posedge aclk);
      chk("frozen command", cmd_active, 1'b1);
      complete_run;
   end
endmodule
